// ---- bench/guard_asserts.sv ----
// Port checker for the power-state guard.
// Assumes CE held high by the bench.
`timescale 1ns/10ps
module guard_asserts (
   // Clock, reset, inputs
   input wire logic CLK,
   input wire logic RST,
   input wire logic DIE_HOT,
   input wire logic DIE_COOL,
   input wire logic AUTO_RESUME,
   input wire logic FW_REENABLE,
   input wire logic ACTIVITY,
   // Outputs
   input wire logic SOURCE_PATH_PORT_A,
   input wire logic SOURCE_PATH_PORT_B,
   input wire logic SINK_GATE_PATH_PORT_A,
   input wire logic SINK_GATE_PATH_PORT_B,
   input wire logic CABLE_SUPPLY_PATH_PORT_A,
   input wire logic CABLE_SUPPLY_PATH_PORT_B,
   input wire logic DIE_SHUTDOWN,
   input wire logic PATH_SHUTDOWN,
   input wire logic [3:0] POWER_STATE
);
   logic [5:0] p;
   // Paths in package bit order
   assign p = {CABLE_SUPPLY_PATH_PORT_B, CABLE_SUPPLY_PATH_PORT_A, SINK_GATE_PATH_PORT_B,
      SINK_GATE_PATH_PORT_A, SOURCE_PATH_PORT_B, SOURCE_PATH_PORT_A};
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   die_off_a: assert property (DIE_SHUTDOWN |-> p == 6'h00) else $error("die path on");
   die_trip_a: assert property (DIE_HOT [*7] |-> DIE_SHUTDOWN) else $error("die trip");
   die_hold_a: assert property (!DIE_COOL [*6] ##0 DIE_SHUTDOWN |=> DIE_SHUTDOWN)
      else $error("die early");
   path_off_a: assert property (PATH_SHUTDOWN |-> (p & 6'h33) == 6'h00) else $error("src on");
   path_hold_a: assert property ((!AUTO_RESUME && !FW_REENABLE) [*6] ##0 PATH_SHUTDOWN
      |=> PATH_SHUTDOWN) else $error("path early");
   sleep_off_a: assert property ((POWER_STATE == 4'h8) [*2] |-> p == 6'h00) else $error("sleep");
   idle_entry_a: assert property (POWER_STATE == 4'h2 && $past(POWER_STATE) != 4'h2
      |-> $past(POWER_STATE) == 4'h1 && !$past(ACTIVITY)) else $error("idle entry");
   idle_wake_a: assert property (POWER_STATE == 4'h2 && ACTIVITY |=> POWER_STATE == 4'h1)
      else $error("no wake");
   cover property ($rose(DIE_SHUTDOWN));
   cover property ($rose(PATH_SHUTDOWN));
   cover property (POWER_STATE == 4'h4);
endmodule
bind power_state_thermal_guard guard_asserts chk (.*);

// ---- bench/host_ctrl_model.sv ----
// Host controller model: loads the boot bundle, then holds it loaded.
// Assumes it leaves reset on the guard's clock and reset.
`timescale 1ns/10ps
module host_ctrl_model #(
   parameter int BOOT = 10
) (
   // Clock, reset and load flag
   input wire logic clk,
   input wire logic rst,
   output logic cfg_loaded
);
   int cnt_q;
   // Boot count, then the bundle stays loaded
   always_ff @(posedge clk) begin
      cnt_q <= rst ? 0 : (cnt_q < BOOT ? cnt_q + 1 : cnt_q);
   end
   assign cfg_loaded = (cnt_q == BOOT);
endmodule

// ---- bench/power_state_thermal_guard_tb.sv ----
// Bench: power states, path trips and die trip with expected paths.
// Assumes the host model finishes boot loading 10 cycles after reset, after the first check and the first wake pulse.
`timescale 1ns/10ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
   $display("BAD %s exp %h got %h", n, e, g); end end
module power_state_thermal_guard_tb;
   logic CLK = 0, RST = 1, dh = 0, dc = 1, ah = 0, bh = 0, ac = 1, bc = 1, cfg, ar = 0;
   logic fw = 0, sr = 1, act = 0, ds, ps;
   logic [1:0] req = 2'h3;
   logic [3:0] st;
   logic [5:0] p;
   int num_errors = 0, checked = 0;
   always #4 CLK = ~CLK;
   power_state_thermal_guard #(.IDLE_COUNT(20)) dut (.CLK(CLK), .RST(RST), .CE(1'b1),
      .DIE_HOT(dh), .DIE_COOL(dc), .PATH_A_HOT(ah), .PATH_B_HOT(bh), .PATH_A_COOL(ac),
      .PATH_B_COOL(bc), .CFG_LOADED(cfg), .AUTO_RESUME(ar), .FW_REENABLE(fw),
      .SOURCE_ROLE(sr), .STATE_REQ(req), .ACTIVITY(act), .SOURCE_PATH_PORT_A(p[0]),
      .SOURCE_PATH_PORT_B(p[1]), .SINK_GATE_PATH_PORT_A(p[2]), .SINK_GATE_PATH_PORT_B(p[3]),
      .CABLE_SUPPLY_PATH_PORT_A(p[4]), .CABLE_SUPPLY_PATH_PORT_B(p[5]),
      .DIE_SHUTDOWN(ds), .PATH_SHUTDOWN(ps), .POWER_STATE(st));
   host_ctrl_model ec (.clk(CLK), .rst(RST), .cfg_loaded(cfg));
   // Wait edges, then settle off the edge
   task step(input int n);
      repeat (n) @(posedge CLK);
      if (n > 0) #1;
   endtask
   // One-cycle wake pulse
   task pulse;
      act = 1;
      step(1);
      act = 0;
   endtask
   // Compare paths, state (skipped when zero) and both flags
   task look(input int n, input logic [5:0] ep, input logic [3:0] es, input logic ed,
      input logic ef);
      step(n);
      `CHK("paths", ep, p)
      if (es != 4'h0) `CHK("state", es, st)
      `CHK("die", ed, ds)
      `CHK("path", ef, ps)
   endtask
   task stop_test;
      if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Watchdog
   initial begin
      repeat (1000) @(posedge CLK);
      num_errors++;
      stop_test;
   end
   // Main sequence
   initial begin
      step(12);
      RST = 0;
      look(2, 6'h00, 4'h1, 0, 0);
      pulse;
      look(12, 6'h33, 4'h1, 0, 0);
      sr = 0;
      look(2, 6'h3c, 4'h1, 0, 0);
      sr = 1;
      pulse;
      look(15, 6'h33, 4'h1, 0, 0);
      look(8, 6'h33, 4'h2, 0, 0);
      pulse;
      look(0, 6'h33, 4'h1, 0, 0);
      req = 2'h1;
      look(26, 6'h01, 4'h4, 0, 0);
      sr = 0;
      look(2, 6'h00, 4'h4, 0, 0);
      sr = 1;
      req = 2'h0;
      look(3, 6'h33, 4'h1, 0, 0);
      req = 2'h2;
      look(3, 6'h00, 4'h8, 0, 0);
      req = 2'h0;
      look(3, 6'h33, 4'h1, 0, 0);
      req = 2'h3;
      ah = 1;
      ac = 0;
      look(8, 6'h00, 4'h0, 0, 1);
      ah = 0;
      ac = 1;
      look(8, 6'h00, 4'h0, 0, 1);
      fw = 1;
      step(2);
      fw = 0;
      look(8, 6'h33, 4'h0, 0, 0);
      ar = 1;
      bh = 1;
      bc = 0;
      look(8, 6'h00, 4'h0, 0, 1);
      bh = 0;
      bc = 1;
      look(8, 6'h33, 4'h0, 0, 0);
      dh = 1;
      dc = 0;
      look(8, 6'h00, 4'h0, 1, 0);
      dh = 0;
      look(8, 6'h00, 4'h0, 1, 0);
      dc = 1;
      look(8, 6'h33, 4'h0, 0, 0);
      stop_test;
   end
endmodule

// ---- design/power_state_thermal_guard.sv ----
// Power-state sequencer with die and source-path thermal shutdown.
// Assumes comparator outputs arrive asynchronously from analog sensors,
// with hysteresis applied by the sensors' separate release outputs.
`timescale 1ns/10ps
module power_state_thermal_guard #(
   parameter int IDLE_COUNT = pwr_guard_pkg::IDLE_CYCLES
) (
   // Clock, reset, enable
   input wire logic CLK,
   input wire logic RST,
   input wire logic CE,
   // Thermal sensors (asynchronous levels)
   input wire logic DIE_HOT,
   input wire logic DIE_COOL,
   input wire logic PATH_A_HOT,
   input wire logic PATH_B_HOT,
   input wire logic PATH_A_COOL,
   input wire logic PATH_B_COOL,
   // Configuration and control from host port
   input wire logic CFG_LOADED,
   input wire logic AUTO_RESUME,
   input wire logic FW_REENABLE,
   input wire logic SOURCE_ROLE,
   input wire logic [1:0] STATE_REQ,
   // Activity events, one-cycle pulses on CLK
   input wire logic ACTIVITY,
   // Path enables and status
   output logic SOURCE_PATH_PORT_A,
   output logic SOURCE_PATH_PORT_B,
   output logic SINK_GATE_PATH_PORT_A,
   output logic SINK_GATE_PATH_PORT_B,
   output logic CABLE_SUPPLY_PATH_PORT_A,
   output logic CABLE_SUPPLY_PATH_PORT_B,
   output logic DIE_SHUTDOWN,
   output logic PATH_SHUTDOWN,
   output logic [3:0] POWER_STATE
);
   import pwr_guard_pkg::*;

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   localparam int NS = 6;
   logic [NS-1:0] raw;
   logic [NS-1:0] s1_q, s2_q, s3_q, flt_q, flt_d;
   assign raw = {PATH_B_COOL, PATH_A_COOL, PATH_B_HOT, PATH_A_HOT, DIE_COOL, DIE_HOT};

   // Stages clear on reset, so cool levels read low for a few cycles;
   // no latch is set then, so the late release level does no harm
   // Accept a change once second and third stages agree
   always_comb begin
      flt_d = flt_q;
      for (int i = 0; i < NS; i++) begin
         if (s2_q[i] == s3_q[i]) begin
            flt_d[i] = s3_q[i];
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         flt_q <= '0;
      end else if (CE) begin
         s1_q <= raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         flt_q <= flt_d;
      end
   end

   logic die_hot, die_cool, pa_hot, pb_hot, pa_cool, pb_cool;
   assign {pb_cool, pa_cool, pb_hot, pa_hot, die_cool, die_hot} = flt_q;

   // ------------------------------------------------------------
   // Thermal shutdown latches
   // ------------------------------------------------------------
   logic die_sd_q, die_sd_d, path_sd_q, path_sd_d;

   // Trips take priority over release in the same cycle
   always_comb begin
      // Only the paths go dark; the state machine keeps supervising
      die_sd_d = die_sd_q;
      if (die_hot) begin
         die_sd_d = 1'b1;
      end else if (die_cool) begin
         die_sd_d = 1'b0;
      end
      // One shared latch for both paths, so release waits for both
      path_sd_d = path_sd_q;
      if (pa_hot || pb_hot) begin
         path_sd_d = 1'b1;
      end else if (pa_cool && pb_cool && (AUTO_RESUME || FW_REENABLE)) begin
         path_sd_d = 1'b0;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         die_sd_q <= 1'b0;
         path_sd_q <= 1'b0;
      end else if (CE) begin
         die_sd_q <= die_sd_d;
         path_sd_q <= path_sd_d;
      end
   end

   // ------------------------------------------------------------
   // Power state machine and idle timer
   // ------------------------------------------------------------
   pwr_state_t st_q, st_d;
   logic [IDLE_CNT_W-1:0] idle_q, idle_d;
   logic idle_done;
   // Counter stops at the limit, so a long quiet spell
   // cannot wrap round and retrigger the Idle entry
   assign idle_done = (idle_q >= IDLE_CNT_W'(IDLE_COUNT - 1));

   // Quiet-interval counter and state sequencing
   always_comb begin
      idle_d = idle_q;
      st_d = st_q;
      if (ACTIVITY || st_q != ST_ACTIVE) begin
         idle_d = '0;
      end else if (!idle_done) begin
         idle_d = idle_q + IDLE_CNT_W'(1);
      end
      // Standby only through Idle; Sleep from Active or Idle
      unique case (st_q)
         ST_ACTIVE: begin
            if (STATE_REQ == REQ_SLEEP) begin
               st_d = ST_SLEEP;
            end else if (idle_done && !ACTIVITY) begin
               st_d = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (ACTIVITY) begin
               st_d = ST_ACTIVE;
            end else if (STATE_REQ == REQ_STANDBY) begin
               st_d = ST_STANDBY;
            end else if (STATE_REQ == REQ_SLEEP) begin
               st_d = ST_SLEEP;
            end
         end
         ST_STANDBY, ST_SLEEP: begin
            if (ACTIVITY || STATE_REQ == REQ_RUN) begin
               st_d = ST_ACTIVE;
            end
         end
         default: st_d = ST_ACTIVE;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         st_q <= ST_ACTIVE;
         idle_q <= '0;
      end else if (CE) begin
         st_q <= st_d;
         idle_q <= idle_d;
      end
   end

   // ------------------------------------------------------------
   // Path enables
   // ------------------------------------------------------------
   logic [PATH_W-1:0] en_q, en_d;

   // Table of enables per state, then thermal overrides
   always_comb begin
      // Paths stay off until the boot bundle is in
      en_d = PATHS_OFF;
      if (CFG_LOADED) begin
         unique case (st_q)
            ST_ACTIVE, ST_IDLE: begin
               en_d[PATH_SRC_A] = SOURCE_ROLE;
               en_d[PATH_SRC_B] = SOURCE_ROLE;
               en_d[PATH_SNK_A] = !SOURCE_ROLE;
               en_d[PATH_SNK_B] = !SOURCE_ROLE;
               en_d[PATH_CBL_A] = 1'b1;
               en_d[PATH_CBL_B] = 1'b1;
            end
            ST_STANDBY: en_d[PATH_SRC_A] = SOURCE_ROLE;
            ST_SLEEP: en_d = PATHS_OFF;
            default: en_d = PATHS_OFF;
         endcase
      end
      // Overrides read the next flag values, so paths drop
      // on the same edge as the shutdown flag rises
      if (path_sd_d) begin
         en_d[PATH_SRC_A] = 1'b0;
         en_d[PATH_SRC_B] = 1'b0;
         en_d[PATH_CBL_A] = 1'b0;
         en_d[PATH_CBL_B] = 1'b0;
      end
      if (die_sd_d) begin
         en_d = PATHS_OFF;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         en_q <= PATHS_OFF;
      end else if (CE) begin
         en_q <= en_d;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // Every output comes straight from a flip-flop
   assign SOURCE_PATH_PORT_A = en_q[PATH_SRC_A];
   assign SOURCE_PATH_PORT_B = en_q[PATH_SRC_B];
   assign SINK_GATE_PATH_PORT_A = en_q[PATH_SNK_A];
   assign SINK_GATE_PATH_PORT_B = en_q[PATH_SNK_B];
   assign CABLE_SUPPLY_PATH_PORT_A = en_q[PATH_CBL_A];
   assign CABLE_SUPPLY_PATH_PORT_B = en_q[PATH_CBL_B];
   assign DIE_SHUTDOWN = die_sd_q;
   assign PATH_SHUTDOWN = path_sd_q;
   assign POWER_STATE = st_q;
endmodule

// ---- design/pwr_guard_pkg.sv ----
// Constants for the power-state and thermal guard block.
// Assumes one 125 MHz clock and thermal comparator levels from analog sensors.
// How it works
// - Die overtemperature shuts all functions except supervision
// - Die shutdown ends below hysteresis release level
// - Either source-path trip kills sources and cable supply
// - Cooled path resumes automatically or waits for firmware
// - Enabled paths follow power state and role
// - Host port configures and controls all options
// - Boot configuration from host or EEPROM
// - Active to Idle only after quiet interval
package pwr_guard_pkg;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 8;
   localparam int IDLE_TIME_US = 1000;
   localparam int IDLE_CYCLES = (IDLE_TIME_US * 1000) / CLK_PERIOD_NS;
   localparam int IDLE_CNT_W = 32;
   // ------------------------------------------------------------
   // Power-state request codes
   // ------------------------------------------------------------
   localparam logic [1:0] REQ_RUN = 2'h0;
   localparam logic [1:0] REQ_STANDBY = 2'h1;
   localparam logic [1:0] REQ_SLEEP = 2'h2;
   // Path enable vector bit positions
   localparam int PATH_SRC_A = 0;
   localparam int PATH_SRC_B = 1;
   localparam int PATH_SNK_A = 2;
   localparam int PATH_SNK_B = 3;
   localparam int PATH_CBL_A = 4;
   localparam int PATH_CBL_B = 5;
   localparam int PATH_W = 6;
   localparam logic [PATH_W-1:0] PATHS_OFF = 6'h00;
   // Power states, one-hot
   typedef enum logic [3:0] {
      ST_ACTIVE = 4'h1,
      ST_IDLE = 4'h2,
      ST_STANDBY = 4'h4,
      ST_SLEEP = 4'h8
   } pwr_state_t;
endpackage
